// ---- src/utf_pkg.sv ----
package utf_pkg;
    // Queue depths and word layouts
    localparam int TX_DEPTH = 128;
    localparam int RX_DEPTH = 16;
    localparam int DATA_W = 8;
    localparam int RXW_W = 11;
    localparam int RXW_PAR = 8;
    localparam int RXW_FRM = 9;
    localparam int RXW_NOISE = 10;
    // Line status bit positions
    localparam int LSR_OVR = 1;
    localparam int LSR_PAR = 2;
    localparam int LSR_FRM = 3;
    localparam int LSR_NOISE = 5;
    // Trigger level is counted in units of eight words
    localparam int TRIG_SHIFT = 3;
    // Rate mode codes and oversampling ticks per bit
    localparam logic [1:0] RATE_1X = 2'h0;
    localparam logic [1:0] RATE_2X = 2'h1;
    localparam logic [1:0] RATE_4X = 2'h2;
    localparam logic [4:0] OSR_1X = 5'h10;
    localparam logic [4:0] OSR_2X = 5'h08;
    localparam logic [4:0] OSR_4X = 5'h04;
    // Multiplier factors by select code, predivider floor
    localparam logic [7:0] PLL_X6 = 8'h06;
    localparam logic [7:0] PLL_X48 = 8'h30;
    localparam logic [7:0] PLL_X96 = 8'h60;
    localparam logic [7:0] PLL_X144 = 8'h90;
    localparam logic [5:0] PREDIV_MIN = 6'h01;
    localparam logic [15:0] DIV_MIN = 16'h0001;
    // Reset values
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic [7:0] LSR_RST = 8'h00;
    // Frame state machines
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
    } utf_tx_st_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
    } utf_rx_st_t;
endpackage

// ---- src/utf_top.sv ----
`timescale 1ns/100ps
module utf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [LW-1:0] cnt_q, cnt_d;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_d = cnt_q + LW'(push) - LW'(pop);
    assign out_data = mem[rp_q];
    assign level = cnt_q;

    // Storage has no reset; only pointers and flags need one
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers and counts; depth must be a power of two for pointer wrap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_d;
            in_ready <= cnt_d != LW'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end
endmodule

module utf_top import utf_pkg::*; #(
    parameter int TXD = TX_DEPTH,
    parameter int RXD = RX_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Host data path
    input wire logic tx_hold_wr,
    input wire logic [7:0] tx_hold_data,
    output logic tx_hold_ready,
    input wire logic rx_hold_rd,
    output logic rx_avail,
    output logic [7:0] rx_hold_reg,
    output logic [7:0] line_status_reg,
    output logic [$clog2(TXD+1)-1:0] tx_fill,
    output logic [$clog2(RXD+1)-1:0] rx_fill,
    // Line control
    input wire logic tx_halt_bit,
    input wire logic rx_halt_bit,
    input wire logic queue_flush_bit,
    input wire logic tx_polarity_flip,
    input wire logic rx_polarity_flip,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic [3:0] queue_trigger_level,
    // Event flags
    input wire logic isr_clear,
    input wire logic sts_clear,
    output logic tx_level_reached_flag,
    output logic tx_queue_drained_flag,
    output logic tx_line_idle_flag,
    output logic osc_settled_flag,
    // Clocking
    input wire logic xtal_select_bit,
    input wire logic osc_stable,
    input wire logic baud_tick_on_flow_pin,
    input wire logic [1:0] mult_select,
    input wire logic [5:0] prediv_value,
    input wire logic [7:0] baud_whole_high_byte,
    input wire logic [7:0] baud_whole_low_byte,
    input wire logic [3:0] sub_step_nibble,
    input wire logic [1:0] rate_mode,
    output logic xtal_enable,
    output logic [7:0] pll_factor,
    output logic [5:0] pll_prediv,
    // Serial line
    input wire logic serial_in,
    output logic serial_out,
    output logic flow_pin_out
);
    localparam int TLW = $clog2(TXD+1);
    logic [1:0] rst_s_q;
    logic rst_n;
    logic [1:0] oss_q, rxs_q;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_n = rst_s_q[1];

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oss_q <= 2'h0;
            rxs_q <= 2'h3;
        end else begin
            oss_q <= {oss_q[0], osc_stable};
            rxs_q <= {rxs_q[0], serial_in};
        end
    end

    // Reference selection and multiplier setup, held for the analog side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xtal_enable <= 1'b0;
            osc_settled_flag <= 1'b0;
            pll_factor <= PLL_X6;
            pll_prediv <= PREDIV_MIN;
        end else begin
            xtal_enable <= xtal_select_bit;
            osc_settled_flag <= xtal_select_bit ? oss_q[1] : 1'b1;
            case (mult_select)
                2'h0: pll_factor <= PLL_X6;
                2'h1: pll_factor <= PLL_X48;
                2'h2: pll_factor <= PLL_X96;
                default: pll_factor <= PLL_X144;
            endcase
            // Zero would stall the divider, so it reads as one
            pll_prediv <= (prediv_value == '0) ? PREDIV_MIN : prediv_value;
        end
    end

    // Fractional baud generator
    logic [15:0] div_w, div_eff;
    logic [16:0] bcnt_q;
    logic [3:0] acc_q;
    logic [4:0] acc_sum;
    logic tick_q;
    logic [4:0] osr, mid;
    assign div_w = {baud_whole_high_byte, baud_whole_low_byte};
    assign div_eff = (div_w < DIV_MIN) ? DIV_MIN : div_w;
    assign acc_sum = {1'b0, acc_q} + {1'b0, sub_step_nibble};

    // Carry of the sixteenth accumulator stretches one period by a cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_q <= '0;
            acc_q <= '0;
            tick_q <= 1'b0;
        end else if (!osc_settled_flag) begin
            bcnt_q <= '0;
            tick_q <= 1'b0;
        end else if (bcnt_q == '0) begin
            tick_q <= 1'b1;
            acc_q <= acc_sum[3:0];
            bcnt_q <= {1'b0, div_eff} + 17'(acc_sum[4]) - 17'h1;
        end else begin
            tick_q <= 1'b0;
            bcnt_q <= bcnt_q - 17'h1;
        end
    end

    // Ticks per bit by rate mode; code 3 behaves as 4x
    always_comb begin
        case (rate_mode)
            RATE_1X: osr = OSR_1X;
            RATE_2X: osr = OSR_2X;
            default: osr = OSR_4X;
        endcase
        mid = osr >> 1;
    end

    // Baud clock onto the flow pin; uneven when a fraction is used
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flow_pin_out <= 1'b0;
        end else begin
            flow_pin_out <= baud_tick_on_flow_pin && (bcnt_q[15:0] >= {1'b0, div_eff[15:1]});
        end
    end

    // Transmit queue
    logic tx_ovalid, tx_pop, tx_push;
    logic [7:0] tx_odata;
    assign tx_push = tx_hold_wr && tx_hold_ready;
    utf_fifo #(.W(DATA_W), .DEPTH(TXD)) u_txq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(queue_flush_bit),
        .in_valid(tx_hold_wr),
        .in_ready(tx_hold_ready),
        .in_data(tx_hold_data),
        .out_valid(tx_ovalid),
        .out_ready(tx_pop),
        .out_data(tx_odata),
        .level(tx_fill)
    );

    // Transmitter frame machine
    utf_tx_st_t tx_st_q;
    logic [4:0] tx_cnt_q;
    logic [2:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic tx_par_q, tx_line_q, tx_bend, tx_done;
    // Halt only blocks the next pop, so a frame in flight completes
    assign tx_pop = (tx_st_q == TX_IDLE) && !tx_halt_bit && tx_ovalid;
    assign tx_bend = tick_q && (tx_cnt_q == osr - 5'h1);
    assign tx_done = (tx_st_q == TX_STOP) && tx_bend;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '0;
            tx_par_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else if (tx_st_q == TX_IDLE) begin
            tx_line_q <= 1'b1;
            tx_cnt_q <= '0;
            if (tx_pop) begin
                tx_sh_q <= tx_odata;
                tx_par_q <= ^tx_odata ^ parity_odd;
                tx_line_q <= 1'b0;
                tx_st_q <= TX_START;
            end
        end else if (tick_q) begin
            tx_cnt_q <= tx_bend ? 5'h0 : tx_cnt_q + 5'h1;
            if (tx_bend) begin
                case (tx_st_q)
                    TX_START: begin
                        tx_line_q <= tx_sh_q[0];
                        tx_bit_q <= '0;
                        tx_st_q <= TX_DATA;
                    end
                    TX_DATA: begin
                        tx_sh_q <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q != 3'h7) begin
                            tx_line_q <= tx_sh_q[1];
                        end else if (parity_en) begin
                            tx_line_q <= tx_par_q;
                            tx_st_q <= TX_PAR;
                        end else begin
                            tx_line_q <= 1'b1;
                            tx_st_q <= TX_STOP;
                        end
                    end
                    TX_PAR: begin
                        tx_line_q <= 1'b1;
                        tx_st_q <= TX_STOP;
                    end
                    default: begin
                        tx_line_q <= 1'b1;
                        tx_st_q <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // Output polarity applied at the pin flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
        end else begin
            serial_out <= tx_line_q ^ tx_polarity_flip;
        end
    end

    // Transmit events; a set in the clear cycle wins
    logic [TLW-1:0] trig_words;
    logic lvl_hit, lvl_hit_q, drain_ev, idle_ev;
    assign trig_words = TLW'(queue_trigger_level) << TRIG_SHIFT;
    assign lvl_hit = tx_fill >= trig_words;
    assign drain_ev = tx_pop && (tx_fill == TLW'(1)) && !tx_push;
    assign idle_ev = tx_done && !tx_ovalid;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_hit_q <= 1'b0;
            tx_level_reached_flag <= 1'b0;
            tx_queue_drained_flag <= 1'b0;
            tx_line_idle_flag <= 1'b0;
        end else begin
            lvl_hit_q <= lvl_hit;
            tx_level_reached_flag <= (lvl_hit && !lvl_hit_q) ||
                (tx_level_reached_flag && !isr_clear);
            tx_queue_drained_flag <= drain_ev || (tx_queue_drained_flag && !isr_clear);
            tx_line_idle_flag <= idle_ev || (tx_line_idle_flag && !sts_clear);
        end
    end

    // Receiver sampling
    utf_rx_st_t rx_st_q;
    logic rx_lvl, rx_prev_q, rx_bend, vote, noisy;
    logic [4:0] rx_cnt_q;
    logic [2:0] rx_bit_q, smp_q;
    logic [7:0] rx_sh_q;
    logic rx_noise_q, rx_perr_q, rx_push_q, rx_iready, ovr_q;
    logic [RXW_W-1:0] rx_word_q;
    logic one_smp;
    assign rx_lvl = rxs_q[1] ^ rx_polarity_flip;
    // Follows the tick count so that code 3 samples like 4x as well
    assign one_smp = (osr == OSR_4X);
    assign rx_bend = tick_q && (rx_cnt_q == osr - 5'h1);
    assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
    assign noisy = (smp_q != 3'h0) && (smp_q != 3'h7);

    // Three samples around mid-bit, or one copied three times in 4x
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= 3'h7;
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_lvl;
            if (tick_q && !one_smp && rx_cnt_q == mid - 5'h1) begin
                smp_q[0] <= rx_lvl;
            end
            if (tick_q && rx_cnt_q == mid) begin
                smp_q[1] <= rx_lvl;
                if (one_smp) begin
                    smp_q[0] <= rx_lvl;
                    smp_q[2] <= rx_lvl;
                end
            end
            if (tick_q && !one_smp && rx_cnt_q == mid + 5'h1) begin
                smp_q[2] <= rx_lvl;
            end
        end
    end

    // Receiver frame machine; halt only blocks a new start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_noise_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_word_q <= '0;
        end else begin
            rx_push_q <= 1'b0;
            if (rx_st_q == RX_IDLE) begin
                rx_cnt_q <= '0;
                if (rx_prev_q && !rx_lvl && !rx_halt_bit) begin
                    rx_noise_q <= 1'b0;
                    rx_perr_q <= 1'b0;
                    rx_st_q <= RX_START;
                end
            end else if (tick_q) begin
                rx_cnt_q <= rx_bend ? 5'h0 : rx_cnt_q + 5'h1;
                if (rx_bend) begin
                    rx_noise_q <= rx_noise_q | noisy;
                    case (rx_st_q)
                        RX_START: begin
                            rx_bit_q <= '0;
                            // A high mid-bit means a glitch, not a start
                            rx_st_q <= vote ? RX_IDLE : RX_DATA;
                        end
                        RX_DATA: begin
                            rx_sh_q <= {vote, rx_sh_q[7:1]};
                            rx_bit_q <= rx_bit_q + 3'h1;
                            if (rx_bit_q == 3'h7) begin
                                rx_st_q <= parity_en ? RX_PAR : RX_STOP;
                            end
                        end
                        RX_PAR: begin
                            rx_perr_q <= ^rx_sh_q ^ vote ^ parity_odd;
                            rx_st_q <= RX_STOP;
                        end
                        default: begin
                            rx_push_q <= 1'b1;
                            rx_word_q <= {rx_noise_q | noisy, !vote, rx_perr_q, rx_sh_q};
                            rx_st_q <= RX_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Receive queue; the line cannot stall, so a full queue drops words
    logic rx_ovalid;
    logic [RXW_W-1:0] rx_odata;
    utf_fifo #(.W(RXW_W), .DEPTH(RXD)) u_rxq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(queue_flush_bit),
        .in_valid(rx_push_q),
        .in_ready(rx_iready),
        .in_data(rx_word_q),
        .out_valid(rx_ovalid),
        .out_ready(rx_hold_rd),
        .out_data(rx_odata),
        .level(rx_fill)
    );

    // Hold and status registers follow each read
    logic [7:0] lsr_d;
    always_comb begin
        lsr_d = LSR_RST;
        lsr_d[LSR_OVR] = ovr_q;
        lsr_d[LSR_PAR] = rx_odata[RXW_PAR];
        lsr_d[LSR_FRM] = rx_odata[RXW_FRM];
        lsr_d[LSR_NOISE] = rx_odata[RXW_NOISE];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold_reg <= HOLD_RST;
            line_status_reg <= LSR_RST;
            rx_avail <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            rx_avail <= rx_ovalid;
            ovr_q <= (rx_push_q && !rx_iready) || (ovr_q && !(rx_hold_rd && rx_ovalid));
            if (rx_hold_rd && rx_ovalid) begin
                rx_hold_reg <= rx_odata[7:0];
                line_status_reg <= lsr_d;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_txq_append;
        tx_push && !tx_pop && !queue_flush_bit |=> tx_fill == $past(tx_fill) + TLW'(1);
    endproperty
    a_txq_append: assert property (p_txq_append) else $error("tx fill did not grow");

    property p_trig_flag;
        lvl_hit && !lvl_hit_q |=> tx_level_reached_flag;
    endproperty
    a_trig_flag: assert property (p_trig_flag) else $error("level flag missed");

    property p_drain_flag;
        drain_ev |=> tx_queue_drained_flag ##1 (tx_queue_drained_flag || $past(isr_clear));
    endproperty
    a_drain_flag: assert property (p_drain_flag) else $error("drained flag missed");

    property p_halt;
        tx_halt_bit && tx_st_q == TX_IDLE |=> tx_st_q == TX_IDLE;
    endproperty
    a_halt: assert property (p_halt) else $error("pop while halted");

    property p_idle_pol;
        tx_st_q == TX_IDLE |=> serial_out == !$past(tx_polarity_flip);
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("idle level wrong");

    property p_read_hold;
        rx_hold_rd && rx_ovalid |=> rx_hold_reg == $past(rx_odata[7:0]) &&
            line_status_reg[LSR_NOISE] == $past(rx_odata[RXW_NOISE]);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("hold register stale");

    property p_no_noise_4x;
        rx_push_q && $past(rate_mode, 2) == RATE_4X && $stable(rate_mode) |->
            !rx_word_q[RXW_NOISE];
    endproperty
    a_no_noise_4x: assert property (p_no_noise_4x) else $error("noise in 4x");

    property p_rx_halt;
        rx_halt_bit && rx_st_q == RX_IDLE |=> rx_st_q == RX_IDLE;
    endproperty
    a_rx_halt: assert property (p_rx_halt) else $error("start while halted");
endmodule

// ---- sim/utf_line_model.sv ----
`timescale 1ns/100ps
module utf_line_model #(
    parameter int BIT_NS = 40
) (
    // Serial lines
    input wire logic line_from_dut,
    output logic line_to_dut
);
    logic [7:0] got_q[$];
    logic [7:0] b;
    // Line idles high until a frame is sent
    initial line_to_dut = 1'b1;
    // Low start, eight data bits LSB first, parity, stop, then idle high
    task automatic send(input logic [7:0] d, input logic p, input logic stop);
        line_to_dut = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            line_to_dut = d[i];
            #(BIT_NS);
        end
        line_to_dut = p;
        #(BIT_NS);
        line_to_dut = stop;
        #(BIT_NS);
        line_to_dut = 1'b1;
        #(3 * BIT_NS);
    endtask
    // Mid-bit capture of frames from the device; no parity bit expected
    always begin
        @(negedge line_from_dut);
        #(BIT_NS / 2);
        for (int i = 0; i < 8; i++) begin
            #(BIT_NS);
            b[i] = line_from_dut;
        end
        #(BIT_NS);
        got_q.push_back(b);
    end
endmodule

// ---- sim/utf_top_tb.sv ----
`timescale 1ns/100ps
module utf_top_tb;
    import utf_pkg::*;
    logic clk_sys, arst_n, tx_hold_wr, rx_hold_rd, tx_halt_bit, rx_halt_bit, queue_flush_bit;
    logic tx_polarity_flip, rx_polarity_flip, parity_en, parity_odd, isr_clear, sts_clear;
    logic xtal_select_bit, osc_stable, baud_tick_on_flow_pin, tx_hold_ready, rx_avail;
    logic tx_level_reached_flag, tx_queue_drained_flag, tx_line_idle_flag, osc_settled_flag;
    logic xtal_enable, serial_in, serial_out, flow_pin_out;
    logic [7:0] tx_hold_data, rx_hold_reg, line_status_reg, tx_fill, pll_factor;
    logic [7:0] baud_whole_high_byte, baud_whole_low_byte, d, s;
    logic [5:0] prediv_value, pll_prediv;
    logic [4:0] rx_fill;
    logic [3:0] queue_trigger_level, sub_step_nibble;
    logic [1:0] mult_select, rate_mode;
    logic [7:0] fac[4] = '{PLL_X6, PLL_X48, PLL_X96, PLL_X144};
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    utf_top i_dut (.clk_sys, .arst_n, .tx_hold_wr, .tx_hold_data, .tx_hold_ready, .rx_hold_rd,
        .rx_avail, .rx_hold_reg, .line_status_reg, .tx_fill, .rx_fill, .tx_halt_bit,
        .rx_halt_bit, .queue_flush_bit, .tx_polarity_flip, .rx_polarity_flip, .parity_en,
        .parity_odd, .queue_trigger_level, .isr_clear, .sts_clear, .tx_level_reached_flag,
        .tx_queue_drained_flag, .tx_line_idle_flag, .osc_settled_flag, .xtal_select_bit,
        .osc_stable, .baud_tick_on_flow_pin, .mult_select, .prediv_value, .baud_whole_high_byte,
        .baud_whole_low_byte, .sub_step_nibble, .rate_mode, .xtal_enable, .pll_factor,
        .pll_prediv, .serial_in, .serial_out, .flow_pin_out);
    // 2x mode with divisor 1 gives eight clocks, 40 ns, per bit
    utf_line_model #(.BIT_NS(40)) m (.line_from_dut(serial_out), .line_to_dut(serial_in));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // A hang costs one mismatch and ends the run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            results();
        end
    end
    task automatic results();
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Writes are left asserted so a loop of them runs back to back
    task automatic wr(input logic [7:0] v);
        @(negedge clk_sys);
        tx_hold_wr = 1'b1;
        tx_hold_data = v;
    endtask
    task automatic rd();
        @(negedge clk_sys);
        rx_hold_rd = 1'b1;
        cy(1);
        rx_hold_rd = 1'b0;
        cy(2);
        d = rx_hold_reg;
        s = line_status_reg;
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && m.got_q.size() < n; i++) cy(1);
    endtask
    task automatic t_tx();
        tx_halt_bit = 1'b1;
        queue_trigger_level = 4'h1;
        // The flag may be left over from reset with a zero level
        isr_clear = 1'b1;
        cy(1);
        isr_clear = 1'b0;
        cy(1);
        chk("level0", 8'h00, {7'h00, tx_level_reached_flag});
        for (int i = 0; i < 8; i++) wr(8'h35 + 8'h1d * i[7:0]);
        cy(1);
        tx_hold_wr = 1'b0;
        cy(2);
        chk("tx_fill", 8'h08, tx_fill);
        chk("level", 8'h01, {7'h00, tx_level_reached_flag});
        isr_clear = 1'b1;
        queue_trigger_level = 4'h2;
        cy(1);
        isr_clear = 1'b0;
        cy(2);
        chk("level2", 8'h00, {7'h00, tx_level_reached_flag});
        tx_halt_bit = 1'b0;
        wait_got(8);
        for (int i = 0; i < 8; i++) chk("tx_byte", 8'h35 + 8'h1d * i[7:0], m.got_q[i]);
        cy(20);
        chk("drained", 8'h01, {7'h00, tx_queue_drained_flag});
        chk("line_idle", 8'h01, {7'h00, tx_line_idle_flag});
        wr(8'h77);
        wr(8'h88);
        cy(1);
        tx_hold_wr = 1'b0;
        for (int i = 0; i < 100 && serial_out !== 1'b0; i++) cy(1);
        tx_halt_bit = 1'b1;
        cy(300);
        chk("halt_cnt", 8'h09, 8'(m.got_q.size()));
        chk("halt_fill", 8'h01, tx_fill);
        for (int i = 0; i < 127; i++) wr(8'h00);
        cy(1);
        tx_hold_wr = 1'b0;
        cy(1);
        chk("full_fill", 8'h80, tx_fill);
        chk("full_ready", 8'h00, {7'h00, tx_hold_ready});
        queue_flush_bit = 1'b1;
        cy(2);
        queue_flush_bit = 1'b0;
        cy(2);
        chk("flush", 8'h00, tx_fill);
        tx_halt_bit = 1'b0;
    endtask
    task automatic t_rx();
        parity_en = 1'b1;
        m.send(8'h5a, ^8'h5a, 1'b1);
        m.send(8'hc3, ~^8'hc3, 1'b1);
        m.send(8'h0f, ^8'h0f, 1'b0);
        chk("avail", 8'h01, {7'h00, rx_avail});
        rd();
        chk("rx0", 8'h5a, d);
        chk("st0", 8'h00, s);
        rd();
        chk("rx1", 8'hc3, d);
        chk("st1", 8'h01 << LSR_PAR, s);
        rd();
        chk("st2", 8'h01 << LSR_FRM, s);
        parity_odd = 1'b1;
        m.send(8'h96, ~^8'h96, 1'b1);
        rd();
        chk("st_odd", 8'h00, s);
        rx_halt_bit = 1'b1;
        cy(2);
        m.send(8'h44, ~^8'h44, 1'b1);
        chk("rx_halt", 8'h00, {3'h0, rx_fill});
        rx_halt_bit = 1'b0;
        // 4x with divisor 2 keeps the same 40 ns bit
        rate_mode = RATE_4X;
        baud_whole_low_byte = 8'h02;
        m.send(8'ha6, ~^8'ha6, 1'b1);
        rd();
        chk("rx4x", 8'ha6, d);
        chk("st4x", 8'h00, s);
    endtask
    task automatic t_clk();
        int hi;
        for (int i = 0; i < 4; i++) begin
            mult_select = i[1:0];
            cy(2);
            chk("pll", fac[i], pll_factor);
        end
        prediv_value = 6'h00;
        cy(2);
        chk("prediv0", 8'h01, {2'h0, pll_prediv});
        prediv_value = 6'h3f;
        cy(2);
        chk("prediv63", 8'h3f, {2'h0, pll_prediv});
        xtal_select_bit = 1'b1;
        osc_stable = 1'b0;
        cy(4);
        chk("xtal_en", 8'h01, {7'h00, xtal_enable});
        chk("settled0", 8'h00, {7'h00, osc_settled_flag});
        osc_stable = 1'b1;
        cy(6);
        chk("settled1", 8'h01, {7'h00, osc_settled_flag});
        xtal_select_bit = 1'b0;
        baud_whole_low_byte = 8'h02;
        baud_tick_on_flow_pin = 1'b1;
        cy(4);
        hi = 0;
        for (int i = 0; i < 16; i++) begin
            cy(1);
            hi += int'(flow_pin_out === 1'b1);
        end
        chk("flow_pin", 8'h08, 8'(hi));
        // Half a step: periods of 2 and 3 clocks, 3 high in every 5
        sub_step_nibble = 4'h8;
        cy(6);
        hi = 0;
        for (int i = 0; i < 20; i++) begin
            cy(1);
            hi += int'(flow_pin_out === 1'b1);
        end
        chk("frac", 8'h0c, 8'(hi));
        tx_polarity_flip = 1'b1;
        cy(3);
        chk("tx_flip", 8'h00, {7'h00, serial_out});
    endtask
    initial begin
        {tx_hold_wr, rx_hold_rd, tx_halt_bit, rx_halt_bit, queue_flush_bit} = 5'h00;
        {tx_polarity_flip, rx_polarity_flip, parity_en, parity_odd, isr_clear} = 5'h00;
        {sts_clear, xtal_select_bit, osc_stable, baud_tick_on_flow_pin} = 4'h0;
        tx_hold_data = 8'h00;
        queue_trigger_level = 4'h0;
        mult_select = 2'h0;
        prediv_value = 6'h01;
        baud_whole_high_byte = 8'h00;
        baud_whole_low_byte = 8'h01;
        sub_step_nibble = 4'h0;
        rate_mode = RATE_2X;
        arst_n = 1'b0;
        cy(12);
        arst_n = 1'b1;
        cy(4);
        t_tx();
        t_rx();
        t_clk();
        results();
    end
endmodule
